// [tmr_cfg.svh]
// constants of the timer subsystem: counts, widths, indices, reset values
// assumes one 125 MHz clock; all configuration arrives on plain ports
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH
`define TMR_NT 8
`define TMR_NCT 7
`define TMR_NCH 4
`define TMR_ADV 0
`define TMR_WIDE 1
`define TMR_MID 2
`define TMR_BASIC 7
`define TMR_NPAIR 3
`define TMR_PSC_W 16
`define TMR_CNT_W 32
`define TMR_NARROW_MASK 32'h0000ffff
`define TMR_SEL_W 3
`define TMR_DT_W 8
`define TMR_NSYNC 37
`define TMR_FWD_W 12
`define TMR_FWD_PSC_W 8
`define TMR_FWD_RST 12'hfff
`define TMR_WWD_W 7
`define TMR_WWD_RST 7'h7f
`define TMR_WWD_EARLY 7'h41
`define TMR_WWD_LAST 7'h40
`define TMR_WWD_DIV 4096
`define TMR_WWD_PC_W 13
`define TMR_ST_W 24
`define TMR_ST_DIV_MAX 3'h7
`endif

// [tmr_pkg.sv]
// types shared by the timer subsystem modules
// assumes tmr_cfg.svh supplies the widths
package tmr_pkg;
   typedef enum logic [1:0] {
      CH_OFF = 2'h0,
      CH_CAPTURE = 2'h1,
      CH_COMPARE = 2'h2,
      CH_PWM = 2'h3
   } tmr_ch_mode_e;
   typedef enum logic [1:0] {
      SL_FREE = 2'h0,
      SL_ENCODER = 2'h1,
      SL_GATED = 2'h2,
      SL_RESET = 2'h3
   } tmr_slave_e;
   typedef enum logic [3:0] {
      DT_LO = 4'h1,
      DT_TO_HI = 4'h2,
      DT_HI = 4'h4,
      DT_TO_LO = 4'h8
   } tmr_dt_e;
endpackage

// [tmr_sync.sv]
// two-stage synchroniser bank for pin inputs
// assumes inputs are asynchronous to ref_clk
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module tmr_sync
   import tmr_pkg::*;
#(
   parameter int W = `TMR_NSYNC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } tmr_sync_s;
   tmr_sync_s r;
   tmr_sync_s next_r;
   always_comb begin
      next_r = r;
      if (ce) begin
         next_r.s1 = d;
         next_r.s2 = r.s1;
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
   assign q = r.s2;
endmodule

// [tmr_deadtime.sv]
// one complementary output pair with a dead-time gap between sides
// assumes ref is a registered PWM reference on the same clock
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module tmr_deadtime
   import tmr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic pwm_ref,
   input wire logic [`TMR_DT_W-1:0] dead_time,
   output logic out_hi,
   output logic out_lo
);
   typedef struct packed {
      tmr_dt_e st;
      logic [`TMR_DT_W-1:0] gap;
      logic hi;
      logic lo;
   } tmr_dt_s;
   tmr_dt_s r;
   tmr_dt_s next_r;
   always_comb begin
      next_r = r;
      if (ce) begin
         next_r.gap = r.gap + `TMR_DT_W'(1);
         case (r.st)
            DT_LO: begin
               next_r.gap = '0;
               if (pwm_ref) next_r.st = DT_TO_HI;
            end
            DT_TO_HI: begin
               if (!pwm_ref) next_r.st = DT_LO;
               else if (r.gap >= dead_time) next_r.st = DT_HI;
            end
            DT_HI: begin
               next_r.gap = '0;
               if (!pwm_ref) next_r.st = DT_TO_LO;
            end
            DT_TO_LO: begin
               if (pwm_ref) next_r.st = DT_HI;
               else if (r.gap >= dead_time) next_r.st = DT_LO;
            end
            default: next_r.st = DT_LO;
         endcase
         // both sides stay off through the gap states
         next_r.hi = (next_r.st == DT_HI);
         next_r.lo = (next_r.st == DT_LO);
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         r <= '{st: DT_LO, gap: '0, hi: 1'b0, lo: 1'b0};
      end else begin
         r <= next_r;
      end
   end
   assign out_hi = r.hi;
   assign out_lo = r.lo;
endmodule

// [tmr_top.sv]
// timer subsystem: seven channel timers, basic timer, two watchdogs, system tick
// assumes pins arrive asynchronous; configuration and strobes are on ref_clk
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module tmr_top
   import tmr_pkg::*;
#(
   parameter int WWD_DIV = `TMR_WWD_DIV
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic deep_sleep,
   input wire logic debug_halt,
   input wire logic [`TMR_NT-1:0] tim_en,
   input wire logic [`TMR_NT-1:0] tim_dir_down,
   input wire logic [`TMR_NT-1:0] tim_center,
   input wire logic [`TMR_NT-1:0] tim_one_pulse,
   input wire logic [`TMR_NT-1:0][`TMR_PSC_W-1:0] tim_psc,
   input wire logic [`TMR_NT-1:0][`TMR_CNT_W-1:0] tim_reload,
   input wire logic [`TMR_NT-1:0][1:0] tim_slave,
   input wire logic [`TMR_NT-1:0][`TMR_SEL_W-1:0] tim_trig_sel,
   input wire logic [`TMR_NT-1:0] tim_ext_trig,
   input wire logic [`TMR_NCT-1:0][`TMR_NCH-1:0][1:0] ch_mode,
   input wire logic [`TMR_NCT-1:0][`TMR_NCH-1:0][`TMR_CNT_W-1:0] ch_cmp,
   input wire logic [`TMR_NCT-1:0][`TMR_NCH-1:0] ch_in,
   input wire logic [`TMR_DT_W-1:0] adv_dead_time,
   input wire logic [`TMR_SEL_W-1:0] adc_trig_sel,
   input wire logic [`TMR_SEL_W-1:0] dac_trig_sel,
   input wire logic lirc_in,
   input wire logic fwd_en,
   input wire logic fwd_reset_mode,
   input wire logic [`TMR_FWD_PSC_W-1:0] fwd_psc,
   input wire logic [`TMR_FWD_W-1:0] fwd_reload,
   input wire logic fwd_kick,
   input wire logic wwd_en,
   input wire logic wwd_load,
   input wire logic [`TMR_WWD_W-1:0] wwd_value,
   input wire logic [`TMR_WWD_W-1:0] wwd_window,
   input wire logic st_en,
   input wire logic st_src_div,
   input wire logic st_int_en,
   input wire logic [`TMR_ST_W-1:0] st_reload,
   input wire logic st_flag_clr,
   output logic [`TMR_NT-1:0][`TMR_CNT_W-1:0] tim_count,
   output logic [`TMR_NT-1:0] tim_update,
   output logic [`TMR_NCT-1:0][`TMR_NCH-1:0] ch_out,
   output logic [`TMR_NCT-1:0][`TMR_NCH-1:0][`TMR_CNT_W-1:0] ch_capture,
   output logic [`TMR_NPAIR-1:0] adv_out_hi,
   output logic [`TMR_NPAIR-1:0] adv_out_lo,
   output logic adc_trig,
   output logic dac_trig,
   output logic [`TMR_FWD_W-1:0] fwd_count,
   output logic fwd_reset,
   output logic fwd_timeout,
   output logic [`TMR_WWD_W-1:0] wwd_count,
   output logic wwd_reset,
   output logic wwd_early,
   output logic [`TMR_ST_W-1:0] st_count,
   output logic st_irq,
   output logic st_flag
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [`TMR_NT-1:0][`TMR_CNT_W-1:0] cnt;
      logic [`TMR_NT-1:0][`TMR_PSC_W-1:0] pc;
      logic [`TMR_NT-1:0] dir_dn;
      logic [`TMR_NT-1:0] stop;
      logic [`TMR_NT-1:0] upd;
      logic [`TMR_NT-1:0] trig_prev;
      logic [`TMR_NCT-1:0][`TMR_NCH-1:0] in_prev;
      logic [`TMR_NCT-1:0][`TMR_NCH-1:0] out;
      logic [`TMR_NCT-1:0][`TMR_NCH-1:0][`TMR_CNT_W-1:0] cap;
      logic adc_trig;
      logic dac_trig;
      logic lirc_prev;
      logic [`TMR_FWD_W-1:0] fwd_cnt;
      logic [`TMR_FWD_PSC_W-1:0] fwd_pc;
      logic fwd_rst;
      logic fwd_tmo;
      logic [`TMR_WWD_W-1:0] wwd_cnt;
      logic [`TMR_WWD_PC_W-1:0] wwd_pc;
      logic wwd_rst;
      logic wwd_early;
      logic [`TMR_ST_W-1:0] st_cnt;
      logic [2:0] st_div;
      logic st_irq;
      logic st_flag;
   } tmr_top_s;

   tmr_top_s r;
   tmr_top_s next_r;

   logic [`TMR_NSYNC-1:0] sync_q;
   logic [`TMR_NCT-1:0][`TMR_NCH-1:0] ch_s;
   logic [`TMR_NT-1:0] ext_s;
   logic lirc_s;

   // ************************************************************
   // helpers
   // ************************************************************
   // only the wide timer keeps the upper counter half
   function automatic logic [`TMR_CNT_W-1:0] tmr_mask(input int t);
      return (t == `TMR_WIDE) ? '1 : `TMR_NARROW_MASK;
   endfunction

   // small and basic timers are wired up-only outside encoder mode
   function automatic logic tmr_updown(input int t);
      return (t <= `TMR_MID);
   endfunction

   // returns {update, next direction, next count}
   function automatic logic [`TMR_CNT_W+1:0] tmr_step(
      input logic [`TMR_CNT_W-1:0] c,
      input logic [`TMR_CNT_W-1:0] a,
      input logic dn,
      input logic ctr
   );
      logic [`TMR_CNT_W-1:0] nc;
      logic nd;
      logic u;
      nc = c + `TMR_CNT_W'(1);
      nd = dn;
      u = 1'b0;
      if (!dn) begin
         if (c >= a) begin
            u = 1'b1;
            nd = ctr;
            nc = ctr ? c - `TMR_CNT_W'(1) : '0;
         end
      end else if (c == '0) begin
         u = 1'b1;
         nd = !ctr;
         nc = ctr ? `TMR_CNT_W'(1) : a;
      end else begin
         nc = c - `TMR_CNT_W'(1);
      end
      return {u, nd, nc};
   endfunction

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   tmr_sync #(
      .W(`TMR_NSYNC)
   ) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .d({lirc_in, tim_ext_trig, ch_in}),
      .q(sync_q)
   );

   assign ch_s = sync_q[`TMR_NCT*`TMR_NCH-1:0];
   assign ext_s = sync_q[`TMR_NSYNC-2:`TMR_NCT*`TMR_NCH];
   assign lirc_s = sync_q[`TMR_NSYNC-1];

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      logic [`TMR_CNT_W-1:0] m;
      logic [`TMR_CNT_W+1:0] res;
      logic trig;
      logic go;
      logic tick;
      logic clr;
      logic enc;
      logic edn;
      logic dn;
      logic ctr;
      logic ein;
      logic [`TMR_CNT_W-1:0] cv;
      m = '0;
      res = '0;
      trig = 1'b0;
      go = 1'b0;
      tick = 1'b0;
      clr = 1'b0;
      enc = 1'b0;
      edn = 1'b0;
      dn = 1'b0;
      ctr = 1'b0;
      ein = 1'b0;
      cv = '0;
      next_r = r;
      if (ce) begin
         next_r.upd = '0;
         next_r.fwd_rst = 1'b0;
         next_r.fwd_tmo = 1'b0;
         next_r.wwd_rst = 1'b0;
         next_r.wwd_early = 1'b0;
         next_r.st_irq = 1'b0;
         next_r.trig_prev = '0;
         next_r.in_prev = ch_s;
         next_r.lirc_prev = lirc_s;
         for (int t = 0; t < `TMR_NT; t++) begin
            m = tmr_mask(t);
            // trigger from own pin or another timer
            trig = (tim_trig_sel[t] == `TMR_SEL_W'(t)) ? ext_s[t]
                   : r.upd[tim_trig_sel[t]];
            next_r.trig_prev[t] = trig;
            go = 1'b0;
            tick = 1'b0;
            clr = 1'b0;
            enc = 1'b0;
            edn = 1'b0;
            if (!tim_en[t]) begin
               next_r.stop[t] = 1'b0;
               next_r.pc[t] = '0;
            end else if (!r.stop[t] && !deep_sleep) begin
               case (tim_slave[t])
                  SL_ENCODER: begin
                     // quadrature decode, four counts per cycle
                     if (t < `TMR_NCT) begin
                        tick = (ch_s[t][0] ^ r.in_prev[t][0])
                               | (ch_s[t][1] ^ r.in_prev[t][1]);
                        edn = !(ch_s[t][0] ^ r.in_prev[t][1]);
                        enc = 1'b1;
                     end
                  end
                  SL_GATED: go = trig;
                  SL_RESET: begin
                     go = 1'b1;
                     clr = trig && !r.trig_prev[t];
                  end
                  default: go = 1'b1;
               endcase
               if (go) begin
                  if (r.pc[t] >= tim_psc[t]) begin
                     next_r.pc[t] = '0;
                     tick = 1'b1;
                  end else begin
                     next_r.pc[t] = r.pc[t] + `TMR_PSC_W'(1);
                  end
               end
            end
            // direction allowed per timer width class
            ctr = tim_center[t] && tmr_updown(t) && !enc;
            dn = enc ? edn
                 : ctr ? r.dir_dn[t]
                 : (tim_dir_down[t] && tmr_updown(t));
            if (clr) begin
               next_r.cnt[t] = '0;
               next_r.pc[t] = '0;
            end else if (tick) begin
               res = tmr_step(r.cnt[t] & m, tim_reload[t] & m, dn, ctr);
               next_r.cnt[t] = res[`TMR_CNT_W-1:0] & m;
               next_r.dir_dn[t] = res[`TMR_CNT_W];
               next_r.upd[t] = res[`TMR_CNT_W+1];
               if (res[`TMR_CNT_W+1] && tim_one_pulse[t] && !enc) begin
                  next_r.stop[t] = 1'b1;
               end
            end else if (!ctr) begin
               next_r.dir_dn[t] = dn;
            end
            // same channel logic for every channel timer
            if (t < `TMR_NCT) begin
               for (int c = 0; c < `TMR_NCH; c++) begin
                  ein = ch_s[t][c] && !r.in_prev[t][c];
                  cv = ch_cmp[t][c] & m;
                  case (ch_mode[t][c])
                     CH_CAPTURE: begin
                        next_r.out[t][c] = 1'b0;
                        if (ein) next_r.cap[t][c] = r.cnt[t];
                     end
                     CH_COMPARE: begin
                        if (tick && next_r.cnt[t] == cv) begin
                           next_r.out[t][c] = !r.out[t][c];
                        end
                     end
                     // edge or center PWM from the same compare
                     CH_PWM: next_r.out[t][c] = (next_r.cnt[t] < cv);
                     default: next_r.out[t][c] = 1'b0;
                  endcase
               end
            end
         end
         // update event to the DAC trigger
         next_r.dac_trig = r.upd[dac_trig_sel];
         // update event to the ADC trigger, except from the basic timer
         next_r.adc_trig = r.upd[adc_trig_sel] && (adc_trig_sel != `TMR_BASIC);

         // ******************************************************
         // independent watchdog
         // ******************************************************
         if (fwd_kick) begin
            next_r.fwd_cnt = fwd_reload;
            next_r.fwd_pc = '0;
         // steps on slow oscillator rising edges, ignores sleep
         end else if (fwd_en && lirc_s && !r.lirc_prev) begin
            if (r.fwd_pc >= fwd_psc) begin
               next_r.fwd_pc = '0;
               if (r.fwd_cnt == '0) begin
                  next_r.fwd_cnt = fwd_reload;
                  next_r.fwd_rst = fwd_reset_mode;
                  next_r.fwd_tmo = !fwd_reset_mode;
               end else begin
                  next_r.fwd_cnt = r.fwd_cnt - `TMR_FWD_W'(1);
               end
            end else begin
               next_r.fwd_pc = r.fwd_pc + `TMR_FWD_PSC_W'(1);
            end
         end

         // ******************************************************
         // window watchdog
         // ******************************************************
         if (wwd_load) begin
            // refresh above the window is a fault
            next_r.wwd_rst = wwd_en && (r.wwd_cnt > wwd_window);
            next_r.wwd_cnt = wwd_value;
            next_r.wwd_pc = '0;
         end else if (!debug_halt && !deep_sleep) begin
            if (r.wwd_pc >= `TMR_WWD_PC_W'(WWD_DIV - 1)) begin
               next_r.wwd_pc = '0;
               next_r.wwd_cnt = r.wwd_cnt - `TMR_WWD_W'(1);
               // early warning one step before reset
               next_r.wwd_early = (r.wwd_cnt == `TMR_WWD_EARLY);
               next_r.wwd_rst = wwd_en && (r.wwd_cnt == `TMR_WWD_LAST);
            end else begin
               next_r.wwd_pc = r.wwd_pc + `TMR_WWD_PC_W'(1);
            end
         end

         // ******************************************************
         // system tick
         // ******************************************************
         // clear first, so a zero event in the same cycle wins
         if (st_flag_clr) begin
            next_r.st_flag = 1'b0;
         end
         if (st_en && !deep_sleep) begin
            // clock source: every cycle or one in eight
            next_r.st_div = r.st_div + 3'h1;
            if (!st_src_div || r.st_div == `TMR_ST_DIV_MAX) begin
               if (r.st_cnt == '0) begin
                  next_r.st_cnt = st_reload;
               end else begin
                  next_r.st_cnt = r.st_cnt - `TMR_ST_W'(1);
                  if (r.st_cnt == `TMR_ST_W'(1)) begin
                     next_r.st_irq = st_int_en;
                     next_r.st_flag = 1'b1;
                  end
               end
            end
         end
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         r <= '0;
         r.fwd_cnt <= `TMR_FWD_RST;
         r.wwd_cnt <= `TMR_WWD_RST;
      end else begin
         r <= next_r;
      end
   end

   // ************************************************************
   // advanced timer complementary pairs
   // ************************************************************
   for (genvar k = 0; k < `TMR_NPAIR; k++) begin : g_pair
      tmr_deadtime u_dt (
         .ref_clk(ref_clk),
         .rst(rst),
         .ce(ce),
         .pwm_ref(r.out[`TMR_ADV][k]),
         .dead_time(adv_dead_time),
         .out_hi(adv_out_hi[k]),
         .out_lo(adv_out_lo[k])
      );
   end

   assign tim_count = r.cnt;
   assign tim_update = r.upd;
   assign ch_out = r.out;
   assign ch_capture = r.cap;
   assign adc_trig = r.adc_trig;
   assign dac_trig = r.dac_trig;
   assign fwd_count = r.fwd_cnt;
   assign fwd_reset = r.fwd_rst;
   assign fwd_timeout = r.fwd_tmo;
   assign wwd_count = r.wwd_cnt;
   assign wwd_reset = r.wwd_rst;
   assign wwd_early = r.wwd_early;
   assign st_count = r.st_cnt;
   assign st_irq = r.st_irq;
   assign st_flag = r.st_flag;
endmodule

// [tmr_asserts.sv]
// concurrent checks on the timer subsystem ports
// assumes binding into tmr_top; pulses are one ref_clk cycle wide
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module tmr_asserts
   import tmr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic debug_halt,
   input wire logic wwd_load,
   input wire logic [`TMR_SEL_W-1:0] dac_trig_sel,
   input wire logic [`TMR_NT-1:0][`TMR_CNT_W-1:0] tim_count,
   input wire logic [`TMR_NT-1:0] tim_update,
   input wire logic [`TMR_NPAIR-1:0] adv_out_hi,
   input wire logic [`TMR_NPAIR-1:0] adv_out_lo,
   input wire logic dac_trig,
   input wire logic fwd_reset,
   input wire logic fwd_timeout,
   input wire logic [`TMR_WWD_W-1:0] wwd_count,
   input wire logic wwd_early,
   input wire logic [`TMR_ST_W-1:0] st_count,
   input wire logic st_irq,
   input wire logic st_flag
);
   // ****************************************
   // port relations
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_small_up: assert property ($changed(tim_count[3]) |->
      tim_count[3] == $past(tim_count[3]) + 32'h1 || tim_count[3] == 32'h0)
      else $error("small timer stepped other than up");
   a_small_wrap: assert property (tim_update[3] |-> tim_count[3] == 32'h0)
      else $error("small timer update without wrap");
   a_mid_narrow: assert property (tim_count[2][31:16] == 16'h0)
      else $error("mid timer count above 16 bits");
   a_pair_gap: assert property ((adv_out_hi & adv_out_lo) == 3'h0)
      else $error("pair sides high together");
   a_dac_follow: assert property ($past(tim_update[7]) && $past(dac_trig_sel) == 3'h7 |->
      dac_trig) else $error("dac trigger missed basic update");
   a_fwd_excl: assert property (!(fwd_reset && fwd_timeout))
      else $error("watchdog reset and timeout together");
   a_wwd_early: assert property (wwd_early |-> wwd_count == 7'h40)
      else $error("early warning off its step");
   a_wwd_freeze: assert property ($past(debug_halt) && !$past(wwd_load) |->
      $stable(wwd_count)) else $error("window count moved in halt");
   a_st_zero: assert property (st_irq |-> st_count == 24'h0 && st_flag)
      else $error("tick interrupt away from zero");
   c_tick: cover property (st_irq);
   c_early: cover property (wwd_early);
   c_dac: cover property (dac_trig);
   c_timeout: cover property (fwd_timeout);
endmodule
bind tmr_top tmr_asserts u_tmr_asserts (.*);

// [tmr_pins.sv]
// far side: the free-running slow oscillator pin
// assumes it starts at time zero and never stops
`timescale 1ns/1ps
module tmr_pins (
   output logic lirc_in
);
   // ****************************************
   // oscillator
   // ****************************************
   // 40 KHz source
   initial begin
      lirc_in = 1'b0;
      forever #12500 lirc_in = ~lirc_in;
   end
endmodule

// [testbench.sv]
// self-checking bench for tmr_top
// assumes tmr_pins supplies the slow oscillator; inputs change on falling edges
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module testbench
   import tmr_pkg::*;
;
   logic ref_clk, rst, ce, deep_sleep, debug_halt, lirc_in, fwd_en, fwd_reset_mode, fwd_kick;
   logic wwd_en, wwd_load, st_en, st_src_div, st_int_en, st_flag_clr;
   logic [`TMR_NT-1:0] tim_en, tim_dir_down, tim_center, tim_one_pulse, tim_ext_trig, tim_update;
   logic [`TMR_NT-1:0][`TMR_PSC_W-1:0] tim_psc;
   logic [`TMR_NT-1:0][`TMR_CNT_W-1:0] tim_reload, tim_count;
   logic [`TMR_NT-1:0][1:0] tim_slave;
   logic [`TMR_NT-1:0][`TMR_SEL_W-1:0] tim_trig_sel;
   logic [`TMR_NCT-1:0][`TMR_NCH-1:0][1:0] ch_mode;
   logic [`TMR_NCT-1:0][`TMR_NCH-1:0][`TMR_CNT_W-1:0] ch_cmp, ch_capture;
   logic [`TMR_NCT-1:0][`TMR_NCH-1:0] ch_in, ch_out;
   logic [`TMR_DT_W-1:0] adv_dead_time;
   logic [`TMR_SEL_W-1:0] adc_trig_sel, dac_trig_sel;
   logic [`TMR_FWD_PSC_W-1:0] fwd_psc;
   logic [`TMR_FWD_W-1:0] fwd_reload, fwd_count;
   logic [`TMR_WWD_W-1:0] wwd_value, wwd_window, wwd_count;
   logic [`TMR_ST_W-1:0] st_reload, st_count;
   logic [`TMR_NPAIR-1:0] adv_out_hi, adv_out_lo;
   logic adc_trig, dac_trig, fwd_reset, fwd_timeout, wwd_reset, wwd_early, st_irq, st_flag;
   int n_errors, n_tests, n, k;
   // small divider keeps the window watchdog run short
   tmr_top #(.WWD_DIV(8)) u_tmr_top (.*);
   tmr_pins u_tmr_pins (.lirc_in(lirc_in));
   // ****************************************
   // helpers
   // ****************************************
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task close_out;
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task t_wwd;
      debug_halt = 1'b1;
      k = wwd_count;
      repeat (20) @(negedge ref_clk);
      chk("halted count", wwd_count, k);
      debug_halt = 1'b0;
      for (n = 0; wwd_early !== 1'b1 && n < 1000; n++) @(negedge ref_clk);
      chk("early count", wwd_count, 32'h40);
      @(negedge ref_clk);
      for (n = 1; wwd_reset !== 1'b1 && n < 100; n++) @(negedge ref_clk);
      chk("early to reset", n, 8);
      wwd_window = 7'h7f;
      wwd_value = 7'h55;
      wwd_load = 1'b1;
      @(negedge ref_clk);
      wwd_load = 1'b0;
      chk("loaded count", wwd_count, 32'h55);
   endtask
   task t_timers;
      tim_psc[3] = 16'h1;
      tim_reload[3] = 32'h2;
      tim_reload[1] = 32'h10000003;
      tim_reload[2] = 32'h00012345;
      tim_dir_down[2:1] = 2'h3;
      tim_reload[4] = 32'h2;
      tim_one_pulse[4] = 1'b1;
      tim_reload[7] = 32'h4;
      tim_reload[0] = 32'h9;
      tim_center[0] = 1'b1;
      ch_mode[0][0] = 2'h3;
      ch_cmp[0][0] = 32'h4;
      adv_dead_time = 8'h2;
      adc_trig_sel = 3'h3;
      dac_trig_sel = 3'h7;
      tim_en = 8'h9f;
      for (n = 0; tim_update[1] !== 1'b1 && n < 20; n++) @(negedge ref_clk);
      chk("wide reload", tim_count[1], 32'h10000003);
      chk("mid reload", tim_count[2], 32'h00002345);
      for (n = 0; tim_update[3] !== 1'b1 && n < 20; n++) @(negedge ref_clk);
      @(negedge ref_clk);
      chk("adc trigger", adc_trig, 1'b1);
      for (n = 1; tim_update[3] !== 1'b1 && n < 20; n++) @(negedge ref_clk);
      chk("small period", n, 6);
      for (n = 0; tim_update[7] !== 1'b1 && n < 20; n++) @(negedge ref_clk);
      @(negedge ref_clk);
      chk("dac trigger", dac_trig, 1'b1);
      chk("one pulse stop", tim_count[4], 32'h0);
   endtask
   task t_chan;
      tim_reload[5] = 32'hff;
      tim_reload[6] = 32'hff;
      tim_slave[5] = 2'h1;
      tim_slave[6] = 2'h2;
      tim_trig_sel[6] = 3'h6;
      ch_mode[6][0] = 2'h1;
      ch_mode[6][1] = 2'h2;
      ch_cmp[6][1] = 32'h5;
      tim_en[6:5] = 2'h3;
      repeat (8) @(negedge ref_clk);
      chk("gated hold", tim_count[6], 32'h0);
      tim_ext_trig[6] = 1'b1;
      ch_in[5][0] = 1'b1;
      repeat (8) @(negedge ref_clk);
      ch_in[5][1] = 1'b1;
      ch_in[6][0] = 1'b1;
      k = tim_count[6];
      repeat (4) @(negedge ref_clk);
      chk("capture", ch_capture[6][0], k + 2);
      chk("compare out", ch_out[6][1], 1'b1);
      chk("encoder up", tim_count[5], 32'h2);
      ch_in[5][1] = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk("encoder down", tim_count[5], 32'h1);
   endtask
   task t_tick;
      st_reload = 24'h3;
      st_int_en = 1'b1;
      st_en = 1'b1;
      for (n = 0; st_irq !== 1'b1 && n < 50; n++) @(negedge ref_clk);
      @(negedge ref_clk);
      for (n = 1; st_irq !== 1'b1 && n < 50; n++) @(negedge ref_clk);
      chk("tick period", n, 4);
      st_src_div = 1'b1;
      for (n = 0; st_irq !== 1'b1 && n < 100; n++) @(negedge ref_clk);
      @(negedge ref_clk);
      for (n = 1; st_irq !== 1'b1 && n < 100; n++) @(negedge ref_clk);
      chk("divided period", n, 32);
      st_src_div = 1'b0;
      st_int_en = 1'b0;
      k = 0;
      repeat (12) begin
         @(negedge ref_clk);
         if (st_irq !== 1'b0) k++;
      end
      chk("masked irq", k, 0);
      chk("tick flag", st_flag, 1'b1);
      st_en = 1'b0;
      st_flag_clr = 1'b1;
      @(negedge ref_clk);
      st_flag_clr = 1'b0;
      chk("flag cleared", st_flag, 1'b0);
   endtask
   task t_fwd;
      deep_sleep = 1'b1;
      fwd_reload = 12'h3;
      // start from the short reload, not the full reset count
      fwd_kick = 1'b1;
      @(negedge ref_clk);
      fwd_kick = 1'b0;
      fwd_en = 1'b1;
      for (n = 0; fwd_timeout !== 1'b1 && n < 20000; n++) @(negedge ref_clk);
      chk("timeout pulse", fwd_timeout, 1'b1);
      fwd_reset_mode = 1'b1;
      for (n = 0; fwd_count !== 12'h1 && n < 20000; n++) @(negedge ref_clk);
      fwd_kick = 1'b1;
      @(negedge ref_clk);
      fwd_kick = 1'b0;
      chk("kick reload", fwd_count, 32'h3);
      for (n = 0; fwd_reset !== 1'b1 && n < 20000; n++) @(negedge ref_clk);
      chk("reset pulse", fwd_reset, 1'b1);
   endtask
   // ****************************************
   // sequence
   // ****************************************
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   initial begin
      #600000;
      n_errors++;
      close_out;
   end
   initial begin
      {rst, ce, wwd_en} = 3'h7;
      {deep_sleep, debug_halt, fwd_en, fwd_reset_mode, fwd_kick, wwd_load} = '0;
      {st_en, st_src_div, st_int_en, st_flag_clr, st_reload, fwd_psc, fwd_reload} = '0;
      {tim_en, tim_dir_down, tim_center, tim_one_pulse, tim_ext_trig} = '0;
      {tim_psc, tim_reload, tim_slave, tim_trig_sel, ch_mode, ch_cmp, ch_in} = '0;
      {adv_dead_time, adc_trig_sel, dac_trig_sel, wwd_value, wwd_window} = '0;
      n_errors = 0;
      n_tests = 0;
      repeat (5) @(negedge ref_clk);
      chk("fwd reset value", fwd_count, 32'hfff);
      chk("wwd reset value", wwd_count, 32'h7f);
      rst = 1'b0;
      t_wwd;
      t_timers;
      t_chan;
      t_tick;
      t_fwd;
      close_out;
   end
endmodule
